// ### sar_adc_serial_readout_modes_tb.sv
`timescale 1ns/100ps

// ==========
// bench: host and converter, plus a bench-driven converter
module sar_adc_serial_readout_modes_tb;
    import sar_pkg::*;

    localparam int CONV = 10; // short conversion keeps the run small

    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic start = 1'b0;
    sar_mode_t mode = MODE_SEL;
    logic [15:0] sample_in = 16'h0000; // joined pair analog word
    logic [15:0] sample_b = 16'h0000;  // bench-driven converter word
    logic busy, word_valid, conv_active, conv_b;
    logic [15:0] word;
    logic [31:0] rnd;
    logic [15:0] exp_q[$]; // model: words expected, oldest first
    int seed = 50;
    int err_count = 0;
    int checks_done = 0;
    int cyc = 0;

    sar_link_if link_if();
    sar_link_if fault_if();

    sar_host #(.CONV_CYCLES(CONV)) sar_host_inst (
        .ref_clk(ref_clk), .resetn(resetn), .clk_en(1'b1), .start(start),
        .mode(mode), .busy(busy), .word(word), .word_valid(word_valid),
        .link(link_if.host));
    sar_dev #(.FAR_END(1'b1), .CONV_CYCLES(CONV)) sar_dev_inst (
        .ref_clk(ref_clk), .resetn(resetn), .clk_en(1'b1),
        .sample_in(sample_in), .conv_active(conv_active),
        .link(link_if.dev));
    sar_dev #(.FAR_END(1'b0), .CONV_CYCLES(CONV)) sar_dev_fault_inst (
        .ref_clk(ref_clk), .resetn(resetn), .clk_en(1'b1),
        .sample_in(sample_b), .conv_active(conv_b),
        .link(fault_if.dev));
    sar_link_assertions sar_link_assertions_inst (
        .ref_clk(ref_clk), .resetn(resetn), .sck(link_if.sck),
        .convert_start(link_if.convert_start),
        .serial_select_in(link_if.serial_select_in),
        .serial_result_out(link_if.serial_result_out),
        .serial_result_oe_n(link_if.serial_result_oe_n));

    // ==========
    // clock and hang guard
    always #25 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 40000) begin
            err_count++;
            print_verdict();
        end
    end

    // ==========
    // helpers
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function automatic logic pick(input int s);
        case (s)
            0: return word_valid;
            1: return conv_active;
            default: return busy;
        endcase
    endfunction

    // bounded wait for a level, then compare it
    task automatic wait_sig(input int s, input logic lvl, input int lim);
        int n;
        n = 0;
        while (pick(s) !== lvl && n < lim) begin
            @(posedge ref_clk);
            n++;
        end
        check({15'h0, pick(s)}, {15'h0, lvl});
    endtask

    // one bench clock; select moves at the rise, clear of the capture
    task automatic tick_b(input logic b);
        @(posedge ref_clk);
        fault_if.sck <= 1'b1;
        fault_if.serial_select_in <= b;
        repeat (8) @(posedge ref_clk);
        fault_if.sck <= 1'b0;
        repeat (8) @(posedge ref_clk);
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ==========
    // main sequence
    initial begin
        fault_if.sck = 1'b0;
        fault_if.convert_start = 1'b0;
        fault_if.serial_select_in = 1'b0;
        repeat (4) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (8) @(posedge ref_clk);
        check({15'h0, fault_if.sdo_line}, 16'h0000);
        // every mode three times; even frames run back to back
        for (int i = 0; i < 12; i++) begin
            @(posedge ref_clk);
            rnd = $random(seed);
            sample_in <= rnd[15:0];
            exp_q.push_back(rnd[15:0]);
            mode <= sar_mode_t'(i[1:0]);
            start <= 1'b1;
            @(posedge ref_clk);
            start <= 1'b0;
            wait_sig(1, 1'b1, 80);
            wait_sig(1, 1'b0, 80);
            if (i == 5) begin
                // a start inside a frame is ignored
                start <= 1'b1;
                @(posedge ref_clk);
                start <= 1'b0;
            end
            wait_sig(0, 1'b1, 1500);
            check(word, exp_q.pop_front());
            wait_sig(2, 1'b0, 200);
            if (i[0]) begin
                repeat (6) @(posedge ref_clk);
                check({15'h0, link_if.sdo_line}, 16'h0001);
            end
        end
        // chain frame: result first, then what select fed in
        rnd = $random(seed);
        sample_b <= rnd[15:0];
        @(posedge ref_clk);
        fault_if.convert_start <= 1'b1;
        repeat (40) @(posedge ref_clk);
        check({15'h0, fault_if.sdo_line}, {15'h0, rnd[15]});
        for (int k = 1; k < 32; k++) begin
            tick_b(k <= 16 ? rnd[32-k] : 1'b0);
            check({15'h0, fault_if.sdo_line},
                  {15'h0, k < 16 ? rnd[15-k] : rnd[47-k]});
        end
        // select frame, cut short by select rising mid-word
        fault_if.convert_start <= 1'b0;
        fault_if.serial_select_in <= 1'b1;
        rnd = $random(seed);
        sample_b <= rnd[15:0];
        repeat (8) @(posedge ref_clk);
        fault_if.convert_start <= 1'b1;
        repeat (6) @(posedge ref_clk);
        check({15'h0, fault_if.serial_result_oe_n}, 16'h0001);
        repeat (40) @(posedge ref_clk);
        check({15'h0, fault_if.serial_result_oe_n}, 16'h0001);
        fault_if.serial_select_in <= 1'b0;
        repeat (8) @(posedge ref_clk);
        check({15'h0, fault_if.sdo_line}, {15'h0, rnd[15]});
        for (int k = 1; k < 4; k++) begin
            tick_b(1'b0);
            check({15'h0, fault_if.sdo_line}, {15'h0, rnd[15-k]});
        end
        fault_if.serial_select_in <= 1'b1;
        repeat (8) @(posedge ref_clk);
        check({15'h0, fault_if.serial_result_oe_n}, 16'h0001);
        fault_if.convert_start <= 1'b0;
        repeat (8) @(posedge ref_clk);
        print_verdict();
    end
endmodule

// ### sar_dev.sv
`timescale 1ns/100ps

// ==========
// converter end: readout logic clocked by ref_clk, link clock edges only counted and captured
// How it works
// [RULE1] select level at start picks the mode
// [RULE2] select high: convert, select mode, output off
// [RULE3] host keeps start high through readback
// [RULE4] select and start both low: drive low
// [RULE5] select high over conversion: no indicator
// [RULE6] completion powers converter down until start
// [RULE7] select low gives msb, falls shift
// [RULE8] bits hold across both clock edges
// [RULE9] off after sixteenth fall or select high
// [RULE10] host keeps output contention short
// [RULE11] select low over conversion: indicator
// [RULE12] indicator: low at completion, then msb
// [RULE13] indicator: off after seventeenth fall
// [RULE14] select low, clock low: plain chain
// [RULE15] host keeps start high for chain
// [RULE16] chain: msb at completion, then shift
// [RULE17] chain: select input feeds shift register
// [RULE18] host gives sixteen clocks per device
// [RULE19] select low, clock high: chain indicator
// [RULE20] near end drives high when chain done
// [RULE21] host adds one clock with indicator
// [RULE22] output feeds next select, far tied low
module sar_dev #(
    parameter bit FAR_END = 1'b1,            // select input is tied low
    parameter int CONV_CYCLES = sar_pkg::CONV_CYC
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic [sar_pkg::RES_BITS-1:0] sample_in,
    output logic conv_active,
    sar_link_if.dev link
);
    import sar_pkg::*;

    typedef enum logic [1:0] {
        ST_ACQ,
        ST_CONV,
        ST_READ
    } sar_dev_state_t;

    // ==========
    // link clock domain: edge pointer and chain capture
    logic [PTR_BITS-1:0] ptr_gray_r;     // falling edges seen, gray
    logic [PTR_BITS-1:0] ptr_bin;        // same, binary
    logic chain_buf_r [0:(1<<PTR_BITS)-1]; // captured select bits

    assign ptr_bin = sar_gray2bin(ptr_gray_r);

    // free running pointer: the link clock may stop, so nothing here
    // is cleared per frame; the other domain works relative to it
    always_ff @(negedge link.sck or negedge resetn) begin
        if (!resetn) begin
            ptr_gray_r <= '0;
        end else begin
            ptr_gray_r <= sar_bin2gray(ptr_bin + 1'b1);
        end
    end

    // every falling edge captures the upstream bit
    always_ff @(negedge link.sck) begin
        chain_buf_r[ptr_bin] <= link.serial_select_in; // RULE17
    end

    // ==========
    // pin and pointer synchronisers
    logic cnv_s;                         // start, synchronised
    logic sel_s;                         // select, synchronised
    logic sck_s;                         // clock level, synchronised
    logic [PTR_BITS-1:0] ptr_gray_s;     // pointer, synchronised
    logic [PTR_BITS-1:0] ptr_s;          // pointer, binary

    sar_sync #(.W(3)) u_pin_sync (
        .clk(ref_clk),
        .resetn(resetn),
        .en(clk_en),
        .d({link.convert_start, link.serial_select_in, link.sck}),
        .q({cnv_s, sel_s, sck_s})
    );

    sar_sync #(.W(PTR_BITS)) u_ptr_sync (
        .clk(ref_clk),
        .resetn(resetn),
        .en(clk_en),
        .d(ptr_gray_r),
        .q(ptr_gray_s)
    );

    assign ptr_s = sar_gray2bin(ptr_gray_s);

    // ==========
    // reference domain state
    sar_dev_state_t state_r;
    logic cnv_d_r;                       // start, one cycle back
    logic [15:0] timer_r;                // conversion countdown
    logic chain_r;                       // chain mode latched
    logic ind_r;                         // indicator bit in front
    logic [RES_BITS-1:0] result_r;       // converted word
    logic armed_r;                       // readout window open
    logic [PTR_BITS-1:0] base_r;         // pointer at window open
    logic [PTR_BITS-1:0] ptr_prev_r;     // pointer, one cycle back
    logic [15:0] pos_r;                  // falling edges since open
    logic cnv_rise;
    logic start;
    logic done;
    logic [PTR_BITS-1:0] delta;
    logic [15:0] dpos;
    logic [PTR_BITS-1:0] buf_idx;
    logic bit_nxt;
    logic drive_nxt;

    assign cnv_rise = cnv_s && !cnv_d_r;
    // a running conversion finishes whatever the start pin does
    assign start = cnv_rise && state_r != ST_CONV;
    assign done = state_r == ST_CONV && timer_r == 16'h0000;
    assign delta = ptr_s - ptr_prev_r;
    assign buf_idx = base_r + pos_r[PTR_BITS-1:0] - BUF_LAG;

    // conversion sequencing and converter power
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= ST_ACQ;
            cnv_d_r <= 1'b0;
            timer_r <= 16'h0000;
            conv_active <= 1'b0;
        end else if (clk_en) begin
            cnv_d_r <= cnv_s;
            case (state_r)
                ST_ACQ, ST_READ: begin
                    if (start) begin
                        state_r <= ST_CONV;
                        timer_r <= 16'(CONV_CYCLES - 1);
                        conv_active <= 1'b1;
                    end else if (!cnv_s) begin
                        state_r <= ST_ACQ; // RULE3 RULE15
                    end
                end
                ST_CONV: begin
                    if (done) begin
                        state_r <= ST_READ;
                        conv_active <= 1'b0; // RULE6
                    end else begin
                        timer_r <= timer_r - 16'h0001;
                    end
                end
                default: begin
                    state_r <= ST_ACQ;
                end
            endcase
        end
    end

    // mode latch at start; select mode decides the indicator late
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            chain_r <= 1'b0;
            ind_r <= 1'b0;
        end else if (clk_en) begin
            if (start) begin
                chain_r <= !sel_s; // RULE1 RULE2 RULE14
                ind_r <= !sel_s && sck_s; // RULE19
            end else if (done && !chain_r) begin
                ind_r <= !sel_s; // RULE5 RULE11
            end
        end
    end

    // sampling point: the word is taken as start rises
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            result_r <= RESULT_RST;
        end else if (clk_en && start) begin
            result_r <= sample_in;
        end
    end

    // readout window and edge position
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            armed_r <= 1'b0;
            base_r <= '0;
            ptr_prev_r <= '0;
            pos_r <= 16'h0000;
        end else if (clk_en) begin
            ptr_prev_r <= ptr_s;
            if (start || (state_r == ST_READ && !cnv_s)) begin
                armed_r <= 1'b0;
            end else if (done) begin
                // chain and indicator modes open at completion
                armed_r <= chain_r || !sel_s; // RULE12 RULE16
                base_r <= ptr_s;
                pos_r <= 16'h0000;
            end else if (state_r == ST_READ) begin
                if (!chain_r && sel_s) begin
                    armed_r <= 1'b0; // RULE9 RULE13
                end else if (!chain_r && !armed_r && pos_r == 16'h0000) begin
                    armed_r <= 1'b1; // RULE7
                    base_r <= ptr_s;
                end else if (armed_r) begin
                    pos_r <= pos_r + 16'(delta); // RULE7 RULE16
                end
            end
        end
    end

    // pick the bit that the current edge position shows
    always_comb begin
        dpos = pos_r - {15'h0000, ind_r};
        if (ind_r && pos_r == 16'h0000) begin
            // select mode leads with low, chain with high when ready
            bit_nxt = chain_r && (FAR_END || sel_s); // RULE12 RULE20
        end else if (dpos < 16'(RES_BITS)) begin
            bit_nxt = result_r[4'(RES_BITS - 1) - dpos[3:0]];
        end else begin
            bit_nxt = chain_buf_r[buf_idx]; // RULE16 RULE17
        end
    end

    // when the output is driven at all
    always_comb begin
        if (!cnv_s && !sel_s) begin
            drive_nxt = 1'b1; // RULE4
        end else if (state_r == ST_CONV || start) begin
            // start cycle too, so the pull-up shows no false ready
            drive_nxt = start ? !sel_s : chain_r; // chain holds low
        end else if (state_r == ST_READ && armed_r) begin
            if (chain_r) begin
                drive_nxt = 1'b1;
            end else begin
                drive_nxt = pos_r < 16'(RES_BITS) + {15'h0000, ind_r}; // RULE9 RULE13
            end
        end else begin
            drive_nxt = 1'b0; // RULE2
        end
    end

    // output flops; a bit changes only after a falling edge, so it
    // stands across the next rising and falling edges
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            link.serial_result_out <= 1'b0;
            link.serial_result_oe_n <= 1'b1;
        end else if (clk_en) begin
            link.serial_result_oe_n <= !drive_nxt;
            link.serial_result_out <= drive_nxt && cnv_s && state_r != ST_CONV
                                      && !start && bit_nxt; // RULE8
        end
    end
endmodule

// ### sar_host.sv
`timescale 1ns/100ps

// ==========
// host end: makes the serial clock by dividing ref_clk
module sar_host #(
    parameter int N_DEV = 1,                  // devices in a chain
    parameter int CONV_CYCLES = sar_pkg::CONV_CYC,
    parameter int HALF_CYCLES = sar_pkg::SCK_HALF_CYC
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic start,
    input wire sar_pkg::sar_mode_t mode,
    output logic busy,
    output logic [sar_pkg::RES_BITS-1:0] word,
    output logic word_valid,
    sar_link_if.host link
);
    import sar_pkg::*;

    typedef enum logic [2:0] {
        H_IDLE,
        H_SETUP,
        H_CONV,
        H_SEL,
        H_HI,
        H_LO,
        H_END
    } sar_host_state_t;

    sar_host_state_t state_r;
    sar_mode_t mode_r;
    logic [15:0] timer_r;
    logic [15:0] bit_r;                  // falling edges given so far
    logic [4:0] fill_r;                  // bits in the word so far
    logic [RES_BITS-1:0] shift_r;
    logic cnv_r;
    logic sel_r;
    logic sck_r;
    logic sdo_s;
    logic ind;
    logic [15:0] total;

    assign link.convert_start = cnv_r;
    assign link.serial_select_in = sel_r;
    assign link.sck = sck_r;
    assign ind = mode_r == MODE_SEL_IND || mode_r == MODE_CHAIN_IND;
    // one extra clock carries the indicator bit
    assign total = 16'(RES_BITS * N_DEV) + {15'h0000, ind}; // RULE18 RULE21

    sar_sync #(.W(1)) u_sdo_sync (
        .clk(ref_clk),
        .resetn(resetn),
        .en(clk_en),
        .d(link.sdo_line),
        .q(sdo_s)
    );

    // ==========
    // frame sequencer and pin drivers
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= H_IDLE;
            mode_r <= MODE_SEL;
            timer_r <= 16'h0000;
            bit_r <= 16'h0000;
            cnv_r <= 1'b0;
            sel_r <= 1'b1;
            sck_r <= 1'b0;
            busy <= 1'b0;
        end else if (clk_en) begin
            if (timer_r != 16'h0000) begin
                timer_r <= timer_r - 16'h0001;
            end
            case (state_r)
                H_IDLE: begin
                    if (start) begin
                        mode_r <= mode;
                        busy <= 1'b1;
                        sel_r <= mode == MODE_SEL || mode == MODE_SEL_IND;
                        sck_r <= mode == MODE_CHAIN_IND;
                        bit_r <= 16'h0000;
                        timer_r <= 16'(HALF_CYCLES);
                        state_r <= H_SETUP;
                    end
                end
                H_SETUP: begin
                    if (timer_r == 16'h0000) begin
                        cnv_r <= 1'b1; // RULE3 RULE15
                        timer_r <= 16'(CONV_CYCLES + 2 * HOLD_CYC);
                        state_r <= H_CONV;
                    end
                end
                H_CONV: begin
                    // levels at the start edge are taken; release them
                    if (timer_r == 16'(CONV_CYCLES + HOLD_CYC)) begin
                        sck_r <= 1'b0;
                        if (mode_r == MODE_SEL_IND) begin
                            sel_r <= 1'b0; // RULE11
                        end
                    end
                    if (timer_r < 16'(CONV_CYCLES + HOLD_CYC) && (ind
                        ? sdo_s == (mode_r == MODE_CHAIN_IND)
                        : timer_r == 16'h0000)) begin
                        sel_r <= mode_r == MODE_SEL_IND
                                 || mode_r == MODE_CHAIN_IND ? sel_r : 1'b0;
                        timer_r <= 16'(HALF_CYCLES);
                        state_r <= H_SEL;
                    end
                end
                H_SEL: begin
                    if (timer_r == 16'h0000) begin
                        sck_r <= 1'b1;
                        timer_r <= 16'(HALF_CYCLES);
                        state_r <= H_HI;
                    end
                end
                H_HI: begin
                    if (timer_r == 16'h0000) begin
                        sck_r <= 1'b0;
                        bit_r <= bit_r + 16'h0001;
                        timer_r <= 16'(HALF_CYCLES);
                        state_r <= H_LO;
                    end
                end
                H_LO: begin
                    if (timer_r == 16'h0000) begin
                        sck_r <= bit_r != total;
                        timer_r <= 16'(HALF_CYCLES);
                        state_r <= bit_r == total ? H_END : H_HI;
                    end
                end
                H_END: begin
                    // deselect and drop start in the same cycle so the output is released cleanly
                    sel_r <= 1'b1; // RULE10
                    cnv_r <= 1'b0;
                    busy <= 1'b0;
                    state_r <= H_IDLE;
                end
                default: begin
                    state_r <= H_IDLE;
                end
            endcase
        end
    end

    // sample late in the high half, where the bit is settled
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            fill_r <= 5'h00;
            shift_r <= RESULT_RST;
            word <= RESULT_RST;
            word_valid <= 1'b0;
        end else if (clk_en) begin
            word_valid <= 1'b0;
            if (state_r == H_IDLE) begin
                fill_r <= 5'h00;
            end else if (state_r == H_HI && timer_r == 16'h0000
                         && !(ind && bit_r == 16'h0000)) begin // RULE8
                shift_r <= {shift_r[RES_BITS-2:0], sdo_s};
                if (fill_r == 5'(RES_BITS - 1)) begin
                    fill_r <= 5'h00;
                    word <= {shift_r[RES_BITS-2:0], sdo_s};
                    word_valid <= 1'b1;
                end else begin
                    fill_r <= fill_r + 5'h01;
                end
            end
        end
    end
endmodule

// ### sar_link_assertions.sv
`timescale 1ns/100ps

// ==========
// link checker: watches host and converter on the wire
module sar_link_assertions (
    input logic ref_clk,
    input logic resetn,
    input logic sck,
    input logic convert_start,
    input logic serial_select_in,
    input logic serial_result_out,
    input logic serial_result_oe_n
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    logic sck_q, cnv_q;       // last sampled clock and start
    logic sel_mode_r;         // frame began in select mode
    logic ind_r;              // indicator seen in this frame
    logic [5:0] fall_cnt_r;   // serial clock falls since start

    // ==========
    // frame tracking: count falls, keep the mode
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sck_q <= 1'b0;
            cnv_q <= 1'b0;
            sel_mode_r <= 1'b0;
            fall_cnt_r <= 6'h00;
        end else begin
            sck_q <= sck;
            cnv_q <= convert_start;
            if (convert_start && !cnv_q) begin
                sel_mode_r <= serial_select_in;
                fall_cnt_r <= 6'h00;
            end else if (sck_q && !sck) begin
                fall_cnt_r <= fall_cnt_r + 6'h01;
            end
        end
    end

    // drive that starts long after select fell is the indicator
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ind_r <= 1'b0;
        end else if (convert_start && !cnv_q) begin
            ind_r <= 1'b0;
        end else if ($fell(serial_result_oe_n)
                     && !$past(serial_select_in, 8)) begin
            ind_r <= 1'b1;
        end
    end

    // ==========
    // assertions
    AST_IDLE_LOW: assert property (
        (!serial_select_in && !convert_start)[*6]
        |-> !serial_result_oe_n && !serial_result_out)
        else $error("line not driven low with select and start low");
    AST_SEL_OFF: assert property (
        $rose(convert_start) && serial_select_in |-> ##5 serial_result_oe_n)
        else $error("output driven after select-mode start");
    AST_SEL_RISE: assert property (
        $rose(serial_select_in) |-> ##[1:6] serial_result_oe_n)
        else $error("output not released after select rose");
    AST_BIT_HOLD: assert property (
        $rose(sck) && !serial_result_oe_n
        |-> $stable(serial_result_out) ##1 $stable(serial_result_out))
        else $error("data bit moved around a rising clock edge");
    AST_IND_LOW: assert property (
        $fell(serial_result_oe_n) && !$past(serial_select_in, 8)
        |-> !serial_result_out)
        else $error("indicator not low at completion");
    AST_END_17: assert property (
        sel_mode_r && $rose(fall_cnt_r == 6'h11)
        |-> ##[0:6] serial_result_oe_n)
        else $error("output not released after seventeenth fall");
    AST_END_16: assert property (
        sel_mode_r && !ind_r && $rose(fall_cnt_r == 6'h10)
        |-> ##[0:6] serial_result_oe_n)
        else $error("output not released after sixteenth fall");
    AST_CHAIN_IND: assert property (
        $rose(convert_start) && !serial_select_in && sck
        |-> ##[4:40] (serial_result_out && !serial_result_oe_n))
        else $error("chain indicator never went high");
    AST_CHAIN_PLAIN: assert property (
        $rose(convert_start) && !serial_select_in && !sck
        |-> ##1 (!serial_result_out)[*8])
        else $error("chain output left low level during conversion");

    cover property ($rose(convert_start) && serial_select_in);
    cover property ($rose(convert_start) && !serial_select_in && sck);
    cover property (sel_mode_r && $rose(fall_cnt_r == 6'h11));
endmodule

// ### sar_link_if.sv
`timescale 1ns/100ps

// ==================================================
// serial link between host and converter
interface sar_link_if;
    logic sck;                  // serial clock from the host
    logic convert_start;        // conversion start, rising edge samples
    logic serial_select_in;     // select / chain data input
    logic serial_result_out;    // converter serial data
    logic serial_result_oe_n;   // low while the converter drives data
    logic sdo_line;             // resolved wire level

    // pull-up on the data wire keeps it high when nobody drives
    assign sdo_line = serial_result_oe_n ? 1'b1 : serial_result_out;

    modport dev (
        input sck,
        input convert_start,
        input serial_select_in,
        output serial_result_out,
        output serial_result_oe_n
    );

    modport host (
        output sck,
        output convert_start,
        output serial_select_in,
        input sdo_line
    );
endinterface

// ### sar_pkg.sv
package sar_pkg;

    // ==================================================
    // word and pointer sizes
    localparam int RES_BITS = 16;        // result width
    localparam int PTR_BITS = 5;         // chain capture pointer width
    localparam logic [4:0] BUF_LAG = 5'h10; // capture slot behind shift
    localparam logic [15:0] RESULT_RST = 16'h0000;

    // ==================================================
    // timing, derived from the reference clock period except HOLD_CYC, given in cycles
    localparam int CLK_NS = 50;          // ref_clk period
    localparam int CONV_NS = 2200;       // longest conversion time
    localparam int CONV_CYC = (CONV_NS + CLK_NS - 1) / CLK_NS;
    localparam int SCK_HALF_NS = 400;    // host serial clock half period
    localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOLD_CYC = 4;         // host margin around edges

    // ==================================================
    // readout modes picked at conversion start
    typedef enum logic [1:0] {
        MODE_SEL,
        MODE_SEL_IND,
        MODE_CHAIN,
        MODE_CHAIN_IND
    } sar_mode_t;

    // ==================================================
    // gray helpers for the edge pointer crossing
    function automatic logic [PTR_BITS-1:0] sar_gray2bin(
        input logic [PTR_BITS-1:0] g
    );
        logic [PTR_BITS-1:0] b;
        b[PTR_BITS-1] = g[PTR_BITS-1];
        for (int i = PTR_BITS - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    function automatic logic [PTR_BITS-1:0] sar_bin2gray(
        input logic [PTR_BITS-1:0] b
    );
        return b ^ (b >> 1);
    endfunction

endpackage

// ### sar_sync.sv
`timescale 1ns/100ps

// ==================================================
// two flip-flop synchroniser, first stage read only by the second
module sar_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic en,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r; // may go metastable, read only by the q stage

    // frozen with the clock enable like the host and converter ref_clk state
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_r <= '0;
            q <= '0;
        end else if (en) begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule
